// *** pkg/spcfg_pkg.sv ***
// Constants for the strap-pin configuration loader of a 4:1 video link switch.
// Assumes a single 100 MHz clock domain and static board straps on pins.
// What this block does
// - Enable strap 0 means standby, 1 active.
// - Source code 00..11 routes group A..D.
// - Same code routes auxiliary group A..D.
// - Input terminations off, both registers zero.
// - Equalizer strap copied to all sixteen bits.
// - Equalizer 0 is 6 dB, 1 is 12 dB.
// - Pre-emphasis code 00..11 gives 0/2/4/6 dB.
// - Termination strap 0 off, 1 on.
// - Transmitter image: preemph, termination, current, zeros above.
// - Current strap 0 is 10 mA, 1 is 20 mA.
// - Strap image governs until first serial access.
package spcfg_pkg;
  // Register image width
  localparam int SPCFG_REG_W = 8;
  // Field positions in the mode registers
  localparam int SPCFG_MODE_EN_BIT = 6;
  localparam int SPCFG_MODE_SEL_LSB = 0;
  // Field positions in the transmitter settings image
  localparam int SPCFG_TX_PE_LSB = 2;
  localparam int SPCFG_TX_TERM_BIT = 1;
  localparam int SPCFG_TX_CUR_BIT = 0;
  // Reset values of the image
  localparam logic [7:0] SPCFG_RST_ZERO = 8'h00;
  localparam logic [7:0] SPCFG_RST_AUX = 8'h40;
  // Source group codes
  localparam logic [1:0] SPCFG_SRC_A = 2'h0;
  localparam logic [1:0] SPCFG_SRC_B = 2'h1;
  localparam logic [1:0] SPCFG_SRC_C = 2'h2;
  localparam logic [1:0] SPCFG_SRC_D = 2'h3;
  // Equalizer boost in dB
  localparam int SPCFG_EQ_LOW_DB = 6;
  localparam int SPCFG_EQ_HIGH_DB = 12;
  // Drive current in mA
  localparam int SPCFG_CUR_LOW_MA = 10;
  localparam int SPCFG_CUR_HIGH_MA = 20;
  // Image state
  typedef enum logic [1:0] {SPCFG_LOADING, SPCFG_STRAPPED, SPCFG_SERIAL} spcfg_state_e;
endpackage

// *** src/spcfg_sync.sv ***
// Two-flop synchroniser bank for the static strap pins.
// Assumes pins are asynchronous to clk.
module spcfg_sync
  import spcfg_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [W-1:0] pins, // Raw pins
  output logic [W-1:0] synced // Synchronised copy
);
  logic [W-1:0] meta; // First stage, read only by second
  logic [W-1:0] next_meta; // Next first stage
  logic [W-1:0] next_synced; // Next second stage

  ////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    next_meta = pins;
    next_synced = meta;
  end

  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      synced <= '0;
    end else begin
      meta <= next_meta;
      synced <= next_synced;
    end
  end
endmodule

// *** src/spcfg_loader.sv ***
// Strap configuration image and the routing/analog controls derived from it.
// Assumes straps are static board ties and serial_access marks the first serial
// register access as a one-cycle pulse from same-domain logic.
// Assumes resetn is held for at least one clock edge; the image is taken on
// the third edge after release, once the strap synchroniser has filled.
// The register outputs keep the strap image after the serial hand-over; only
// strap_mode tells downstream logic that serial settings now govern.
module spcfg_loader
  import spcfg_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic strap_hs_enable, // High-speed enable strap
  input wire logic [1:0] strap_source_select, // Source select strap
  input wire logic strap_eq_level, // Equalizer level strap
  input wire logic [1:0] strap_preemph_level, // Pre-emphasis strap
  input wire logic strap_out_term_on, // Output termination strap
  input wire logic strap_out_current, // Output current strap
  input wire logic serial_access, // First serial access pulse
  output logic [7:0] input_term_ctrl_ab, // Input terminations A/B
  output logic [7:0] input_term_ctrl_cd, // Input terminations C/D
  output logic [7:0] rx_equalizer_ab, // Equalizer A/B
  output logic [7:0] rx_equalizer_cd, // Equalizer C/D
  output logic [7:0] transmitter_settings, // Transmitter image
  output logic [7:0] high_speed_modes, // High-speed modes image
  output logic [7:0] auxiliary_modes, // Auxiliary modes image
  output logic hs_standby, // Low-power standby
  output logic [3:0] hs_source_onehot, // High-speed source A..D
  output logic [3:0] aux_common_out, // Auxiliary source A..D
  output logic [4:0] eq_boost_db, // Equalizer boost in dB
  output logic [2:0] preemph_db, // Pre-emphasis in dB
  output logic [4:0] drive_ma, // Drive current in mA
  output logic strap_mode // Strap image governs
);

  ////////////////////////////////////////////////////////////////////////
  // Strap synchronisation
  // Eight strap bits, enable in the top bit down to current in bit 0
  logic [7:0] raw_pins; // Packed straps
  logic [7:0] sync_pins; // Synchronised straps
  assign raw_pins = {strap_hs_enable, strap_source_select, strap_eq_level,
                     strap_preemph_level, strap_out_term_on, strap_out_current};

  // Straps are board ties, but a part may power up with them still settling,
  // so they pass two flops before the capture logic ever looks at them
  spcfg_sync #(.W(8)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pins(raw_pins),
    .synced(sync_pins)
  );

  // Source code to one-hot, used for both switch paths
  function automatic logic [3:0] src_onehot(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      SPCFG_SRC_A: r = 4'h1;
      SPCFG_SRC_B: r = 4'h2;
      SPCFG_SRC_C: r = 4'h4;
      SPCFG_SRC_D: r = 4'h8;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Loader state and image
  spcfg_state_e state; // Image state
  spcfg_state_e next_state; // Next image state
  logic [7:0] image; // Captured straps
  logic [7:0] next_image; // Next captured straps
  logic [1:0] settle; // Sync pipe fill count after release
  logic [1:0] next_settle; // Next fill count

  // Capture while the sync pipe fills; freeze after, hand over on serial access.
  // The sync pipe lags the pins by two edges, so capture stays open until the
  // third edge after release to catch the level present at release.
  always_comb begin
    next_state = state;
    next_image = image;
    next_settle = settle;
    unique case (state)
      SPCFG_LOADING: begin
        next_image = sync_pins;
        next_settle = settle + 2'h1;
        if (settle == 2'h2) begin
          next_state = SPCFG_STRAPPED;
        end
        if (serial_access) begin
          next_state = SPCFG_SERIAL;
        end
      end
      SPCFG_STRAPPED: begin
        if (serial_access) begin
          next_state = SPCFG_SERIAL;
        end
      end
      SPCFG_SERIAL: begin
        next_state = SPCFG_SERIAL; // Held until next reset
      end
      default: next_state = SPCFG_LOADING;
    endcase
  end

  // State registers; the reset branch loads constants only, so the capture
  // restarts from an empty pipe on every reset pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SPCFG_LOADING;
      image <= '0;
      settle <= 2'h0;
    end else begin
      state <= next_state;
      image <= next_image;
      settle <= next_settle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded image fields
  logic s_en; // Enable
  logic [1:0] s_sel; // Source select
  logic s_eq; // Equalizer level
  logic [1:0] s_pe; // Pre-emphasis
  logic s_term; // Output termination
  logic s_cur; // Output current
  assign {s_en, s_sel, s_eq, s_pe, s_term, s_cur} = image;

  // Next register and control values
  // Everything downstream is derived from the frozen image, never from the
  // pins, so a strap that moves after capture cannot reach the outputs
  logic [7:0] next_hs_modes; // Next high-speed modes
  logic [7:0] next_aux_modes; // Next auxiliary modes
  logic [7:0] next_tx; // Next transmitter image
  logic [7:0] next_eq; // Next equalizer image
  logic next_standby; // Next standby
  logic [3:0] next_hs_src; // Next high-speed source
  logic [3:0] next_aux; // Next auxiliary source
  logic [4:0] next_eq_db; // Next equalizer dB
  logic [2:0] next_pe_db; // Next pre-emphasis dB
  logic [4:0] next_ma; // Next drive current
  logic next_strap_mode; // Next strap flag

  // Register images and the analog settings, all from the same image fields.
  // Standby clears only the high-speed route; the auxiliary switch keeps its
  // selection because it carries the low-speed control lines.
  always_comb begin
    next_hs_modes = SPCFG_RST_ZERO;
    next_hs_modes[SPCFG_MODE_EN_BIT] = s_en;
    next_hs_modes[SPCFG_MODE_SEL_LSB +: 2] = s_sel;
    next_aux_modes = SPCFG_RST_AUX;
    next_aux_modes[SPCFG_MODE_SEL_LSB +: 2] = s_sel;
    next_tx = SPCFG_RST_ZERO; // Upper bits zero
    next_tx[SPCFG_TX_PE_LSB +: 2] = s_pe;
    next_tx[SPCFG_TX_TERM_BIT] = s_term;
    next_tx[SPCFG_TX_CUR_BIT] = s_cur;
    next_eq = {8{s_eq}};
    next_standby = !s_en;
    // Standby idles the high-speed path only; the auxiliary path keeps its selection
    next_hs_src = s_en ? src_onehot(s_sel) : 4'h0;
    next_aux = src_onehot(s_sel);
    next_eq_db = s_eq ? 5'(SPCFG_EQ_HIGH_DB) : 5'(SPCFG_EQ_LOW_DB);
    next_pe_db = {s_pe, 1'b0}; // 0/2/4/6 dB
    next_ma = s_cur ? 5'(SPCFG_CUR_HIGH_MA) : 5'(SPCFG_CUR_LOW_MA);
    next_strap_mode = (state != SPCFG_SERIAL);
  end

  // Output registers; terminations never leave zero here
  // Reset values describe the powered-down switch: standby, source A, low levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_term_ctrl_ab <= SPCFG_RST_ZERO;
      input_term_ctrl_cd <= SPCFG_RST_ZERO;
      rx_equalizer_ab <= SPCFG_RST_ZERO;
      rx_equalizer_cd <= SPCFG_RST_ZERO;
      transmitter_settings <= SPCFG_RST_ZERO;
      high_speed_modes <= SPCFG_RST_ZERO;
      auxiliary_modes <= SPCFG_RST_AUX;
      hs_standby <= 1'b1;
      hs_source_onehot <= 4'h0;
      aux_common_out <= 4'h1;
      eq_boost_db <= 5'(SPCFG_EQ_LOW_DB);
      preemph_db <= 3'h0;
      drive_ma <= 5'(SPCFG_CUR_LOW_MA);
      strap_mode <= 1'b1;
    end else begin
      input_term_ctrl_ab <= SPCFG_RST_ZERO;
      input_term_ctrl_cd <= SPCFG_RST_ZERO;
      rx_equalizer_ab <= next_eq;
      rx_equalizer_cd <= next_eq;
      transmitter_settings <= next_tx;
      high_speed_modes <= next_hs_modes;
      auxiliary_modes <= next_aux_modes;
      hs_standby <= next_standby;
      hs_source_onehot <= next_hs_src;
      aux_common_out <= next_aux;
      eq_boost_db <= next_eq_db;
      preemph_db <= next_pe_db;
      drive_ma <= next_ma;
      strap_mode <= next_strap_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_standby_follows: assert property (@(posedge clk) disable iff (!resetn)
    hs_standby == !high_speed_modes[SPCFG_MODE_EN_BIT])
    else $error("standby disagrees with enable bit");
  chk_hs_route: assert property (@(posedge clk) disable iff (!resetn)
    !hs_standby |-> hs_source_onehot == (4'h1 << high_speed_modes[1:0]))
    else $error("high-speed route wrong");
  chk_aux_route: assert property (@(posedge clk) disable iff (!resetn)
    aux_common_out == (4'h1 << auxiliary_modes[1:0]))
    else $error("auxiliary route wrong");
  chk_term_zero: assert property (@(posedge clk) disable iff (!resetn)
    input_term_ctrl_ab == 8'h00 && input_term_ctrl_cd == 8'h00)
    else $error("input termination not zero");
  chk_eq_replica: assert property (@(posedge clk) disable iff (!resetn)
    rx_equalizer_ab == rx_equalizer_cd &&
    (rx_equalizer_ab == 8'h00 || rx_equalizer_ab == 8'hFF))
    else $error("equalizer not replicated");
  chk_eq_db: assert property (@(posedge clk) disable iff (!resetn)
    eq_boost_db == (rx_equalizer_ab[0] ? 5'h0C : 5'h06))
    else $error("equalizer dB wrong");
  chk_preemph_db: assert property (@(posedge clk) disable iff (!resetn)
    preemph_db == {transmitter_settings[3:2], 1'b0})
    else $error("pre-emphasis dB wrong");
  chk_tx_upper: assert property (@(posedge clk) disable iff (!resetn)
    transmitter_settings[7:4] == 4'h0)
    else $error("transmitter upper bits set");
  chk_current_ma: assert property (@(posedge clk) disable iff (!resetn)
    drive_ma == (transmitter_settings[0] ? 5'h14 : 5'h0A))
    else $error("drive current wrong");
  chk_serial_hand: assert property (@(posedge clk) disable iff (!resetn)
    serial_access |-> ##2 !strap_mode)
    else $error("strap mode kept after serial access");
  chk_image_hold: assert property (@(posedge clk) disable iff (!resetn)
    state == SPCFG_STRAPPED && $past(state) == SPCFG_STRAPPED |-> $stable(image))
    else $error("image changed after capture");
  chk_term_out: assert property (@(posedge clk) disable iff (!resetn)
    $past(state) != SPCFG_LOADING |-> transmitter_settings[1] == $past(s_term))
    else $error("output termination wrong");

  ////////////////////////////////////////////////////////////////////////
  // Image shape and hand-over checks
  // These watch the capture window and the frozen outputs as well as the
  // single fields, since a late or repeated capture would pass field checks.

  // Standby idles the high-speed route completely
  chk_standby_idle: assert property (@(posedge clk) disable iff (!resetn)
    hs_standby |-> hs_source_onehot == 4'h0)
    else $error("high-speed route active in standby");

  // Unused high-speed mode bits stay clear
  chk_hs_spare: assert property (@(posedge clk) disable iff (!resetn)
    high_speed_modes[7] == 1'b0 && high_speed_modes[5:2] == 4'h0)
    else $error("high-speed mode spare bits set");

  // Auxiliary switch stays enabled in strap mode
  chk_aux_enable: assert property (@(posedge clk) disable iff (!resetn)
    auxiliary_modes[7:2] == 6'h10)
    else $error("auxiliary enable bits wrong");

  // One source code drives both switch paths
  chk_same_code: assert property (@(posedge clk) disable iff (!resetn)
    high_speed_modes[1:0] == auxiliary_modes[1:0])
    else $error("switch paths disagree on source");

  // Transmitter image follows the image fields one edge later
  chk_tx_fields: assert property (@(posedge clk) disable iff (!resetn)
    transmitter_settings[3:0] == {$past(s_pe), $past(s_term), $past(s_cur)})
    else $error("transmitter fields misplaced");

  // Hand-over is final until the next reset
  chk_serial_stays: assert property (@(posedge clk) disable iff (!resetn)
    !strap_mode |=> !strap_mode)
    else $error("strap mode came back without reset");

  // Straps keep governing until an access is taken
  chk_strap_stays: assert property (@(posedge clk) disable iff (!resetn)
    state != SPCFG_SERIAL |=> strap_mode)
    else $error("strap mode dropped without access");

  // An access in either strap state hands over on the next edge
  chk_serial_take: assert property (@(posedge clk) disable iff (!resetn)
    state != SPCFG_SERIAL && serial_access |=> state == SPCFG_SERIAL)
    else $error("serial access not taken");

  // Capture window never runs past the pipe fill count
  chk_settle_max: assert property (@(posedge clk) disable iff (!resetn)
    state == SPCFG_LOADING |-> settle <= 2'h2)
    else $error("capture window too long");

  // Capture window closes on the third edge after release
  chk_load_exit: assert property (@(posedge clk) disable iff (!resetn)
    state == SPCFG_LOADING && settle == 2'h2 && !serial_access
    |=> state == SPCFG_STRAPPED)
    else $error("capture window did not close");

  // Last capture takes the synchronised pins
  chk_capture_last: assert property (@(posedge clk) disable iff (!resetn)
    state == SPCFG_STRAPPED && $past(state) == SPCFG_LOADING
    |-> image == $past(sync_pins))
    else $error("final capture missed the pins");

  // Outputs hold once the frozen image has reached them
  chk_out_hold: assert property (@(posedge clk) disable iff (!resetn)
    state == SPCFG_STRAPPED && $past(state, 2) == SPCFG_STRAPPED
    |-> $stable(high_speed_modes) && $stable(transmitter_settings) &&
    $stable(rx_equalizer_ab))
    else $error("outputs moved after capture");
endmodule

// *** tb/spcfg_board.sv ***
// Board side of the strap loader: the tied strap pins and the reset driver.
// Assumes clk comes from the bench and that the bench calls the tasks below.
module spcfg_board (
  input wire logic clk, // Bench clock
  output logic resetn, // External reset driver, active low
  output logic [7:0] straps // {enable, source[1:0], eq, preemph[1:0], term, current}
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up: reset held and every strap tied low until the bench loads one
  initial begin
    resetn = 1'b0;
    straps = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restrap the board; the straps only move inside a reset pulse, so the
  // new source code is taken over cleanly when reset is released
  task automatic apply(input logic [7:0] cfg);
    @(negedge clk);
    resetn = 1'b0;
    straps = cfg;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
  endtask

  // Move the straps with no reset pulse; the loader must ignore this
  task automatic jolt(input logic [7:0] cfg);
    @(negedge clk);
    straps = cfg;
  endtask

  // Hold reset low and leave it there until the next apply
  task automatic hold();
    @(negedge clk);
    resetn = 1'b0;
  endtask
endmodule

// *** tb/test_strap_pin_config_image.sv ***
// Self-checking bench for the strap configuration loader.
// Assumes the board model drives straps and reset; outputs are read at falling edges.
module test_strap_pin_config_image;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk; // Bench clock
  logic resetn; // Reset from the board model
  logic [7:0] straps; // Strap pins from the board model
  logic serial_access; // First serial access pulse
  logic [7:0] term_ab, term_cd, eq_ab, eq_cd, tx_set, hs_modes, aux_modes; // Images
  logic hs_standby; // Standby flag
  logic [3:0] hs_src, aux_out; // One-hot routing
  logic [4:0] eq_db, drive_ma; // Analog settings
  logic [2:0] pe_db; // Pre-emphasis in dB
  logic strap_mode; // Strap image governs
  int n_mismatch; // Mismatch count
  int n_tests; // Comparison count

  ////////////////////////////////////////////////////////////////////////////
  // Clock, board and design
  always #5 clk = ~clk;

  spcfg_board u_board (.clk(clk), .resetn(resetn), .straps(straps));

  spcfg_loader u_dut (
    .clk(clk), .resetn(resetn), .strap_hs_enable(straps[7]),
    .strap_source_select(straps[6:5]), .strap_eq_level(straps[4]),
    .strap_preemph_level(straps[3:2]), .strap_out_term_on(straps[1]),
    .strap_out_current(straps[0]), .serial_access(serial_access),
    .input_term_ctrl_ab(term_ab), .input_term_ctrl_cd(term_cd),
    .rx_equalizer_ab(eq_ab), .rx_equalizer_cd(eq_cd), .transmitter_settings(tx_set),
    .high_speed_modes(hs_modes), .auxiliary_modes(aux_modes), .hs_standby(hs_standby),
    .hs_source_onehot(hs_src), .aux_common_out(aux_out), .eq_boost_db(eq_db),
    .preemph_db(pe_db), .drive_ma(drive_ma), .strap_mode(strap_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole image against the strap byte c; mode is the expected governing flag
  task automatic check_image(input logic [7:0] c, input logic mode);
    chk(term_ab, 8'h00);
    chk(term_cd, 8'h00);
    chk(eq_ab, {8{c[4]}});
    chk(eq_cd, {8{c[4]}});
    chk({3'h0, eq_db}, c[4] ? 8'h0C : 8'h06);
    chk({5'h0, pe_db}, {5'h0, c[3:2], 1'b0});
    chk(tx_set, {4'h0, c[3:0]});
    chk({3'h0, drive_ma}, c[0] ? 8'h14 : 8'h0A);
    chk(hs_modes, {1'b0, c[7], 4'h0, c[6:5]});
    chk({7'h0, hs_standby}, {7'h0, ~c[7]});
    chk({4'h0, hs_src}, c[7] ? (8'h01 << c[6:5]) : 8'h00);
    chk({4'h0, aux_out}, 8'h01 << c[6:5]);
    chk(aux_modes, 8'h40 | {6'h00, c[6:5]});
    chk({7'h0, strap_mode}, {7'h0, mode});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Every source, pre-emphasis code and both levels of each flag, each via reset
  task automatic t_codes();
    logic [7:0] tab [8] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h96, 8'h69};
    for (int i = 0; i < 8; i++) begin
      u_board.apply(tab[i]);
      repeat (6) @(negedge clk);
      check_image(tab[i], 1'b1);
    end
  endtask

  // Late strap change ignored, serial hand-over, then reset back to straps
  task automatic t_freeze();
    u_board.apply(8'hFF);
    repeat (6) @(negedge clk);
    u_board.jolt(8'h00);
    repeat (6) @(negedge clk);
    check_image(8'hFF, 1'b1);
    serial_access = 1'b1;
    @(negedge clk);
    serial_access = 1'b0;
    chk({7'h0, strap_mode}, 8'h01);
    repeat (2) @(negedge clk);
    check_image(8'hFF, 1'b0);
    serial_access = 1'b1;
    @(negedge clk);
    serial_access = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h0, strap_mode}, 8'h00);
    u_board.hold();
    @(negedge clk);
    chk({7'h0, strap_mode}, 8'h01);
    chk({7'h0, hs_standby}, 8'h01);
    chk(aux_modes, 8'h40);
    u_board.apply(8'h00);
    repeat (6) @(negedge clk);
    check_image(8'h00, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the board model holds reset for the first four cycles
  initial begin
    clk = 1'b0;
    serial_access = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    t_codes();
    t_freeze();
    complete_run();
  end

  // Watchdog: the tests need about 120 cycles, so 10000 cycles means a hang
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
